// file: core/multipurpose_output_port.sv
// How it works
// - Pin 2 select: latch, A clocks
// - Pin 3 select: latch, timer, B clocks
// - Counter mode: low at terminal, high on stop
// - Pin 4 shows inverted channel A receive ready
// - Pin 5 shows inverted channel B receive ready
// - Pin 6 shows inverted channel A transmit ready
// - Pin 7 shows inverted channel B transmit ready
// - Mode registers hand pins 0, 1 over
// - Start register read starts the timer
// - Stop register read stops the counter
// - Assert write drives marked pins low
// - Negate write drives marked pins high
// - Asserted pin stays low until negated
// - Latch writes ignore alternate function pins
// - Command nibble 8/9 asserts/negates request-to-send
// - Timer mode stop only clears ready flag
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "mpo_params.svh"

module multipurpose_output_port
  import mpo_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic [7:0] chan_a_mode_one_i,
  input wire logic [7:0] chan_a_mode_two_i,
  input wire logic [7:0] chan_b_mode_one_i,
  input wire logic [7:0] chan_b_mode_two_i,
  input wire logic chan_a_alt_i,
  input wire logic chan_b_alt_i,
  input wire logic chan_a_tx_clock_x16_i,
  input wire logic chan_a_tx_clock_x1_i,
  input wire logic chan_a_rx_clock_x1_i,
  input wire logic chan_b_tx_clock_x1_i,
  input wire logic chan_b_rx_clock_x1_i,
  input wire logic timer_mode_i,
  input wire logic ct_out_i,
  input wire logic ct_terminal_i,
  input wire logic [7:0] interrupt_status_i,
  output logic [7:0] output_pin_o,
  output logic timer_start_o,
  output logic timer_halt_o,
  output logic timer_ready_clear_o
);

  byte_type func_sel;
  byte_type gp_latch;
  logic chan_a_request_to_send_n;
  logic ct_low;

  byte_type next_gp_latch;
  byte_type next_rdata;
  byte_type next_pins;
  byte_type alt_mask;
  byte_type assert_mask;
  byte_type negate_mask;
  logic next_rts_n;
  logic next_ct_low;
  logic next_halt;

  logic wr_func;
  logic wr_assert;
  logic wr_negate;
  logic wr_cmd;
  logic rd_start;
  logic rd_stop;
  logic rd_level;
  logic rd_latch;
  logic [3:0] cmd_nib;
  logic rts_on;
  logic rts_off;
  logic pin0_rts;
  logic pin0_alt;
  logic pin0_value;
  logic pin1_alt;
  logic ct_pin_value;

  // Address decode
  assign wr_func = wr_i && (addr_i == `OFS_FUNC_SEL);
  assign wr_assert = wr_i && (addr_i == `OFS_ASSERT);
  assign wr_negate = wr_i && (addr_i == `OFS_NEGATE);
  assign wr_cmd = wr_i && (addr_i == `OFS_CHA_CMD);
  assign rd_start = rd_i && (addr_i == `OFS_START);
  assign rd_stop = rd_i && (addr_i == `OFS_STOP);
  assign rd_level = rd_i && (addr_i == `OFS_PIN_LEVEL);
  assign rd_latch = rd_i && (addr_i == `OFS_GP_LATCH);

  // Request-to-send follows the channel A command nibble
  assign cmd_nib = wdata_i[`CMD_NIB_HI:`CMD_NIB_LO];
  assign rts_on = wr_cmd && (cmd_nib == `CMD_RTS_ON);
  assign rts_off = wr_cmd && (cmd_nib == `CMD_RTS_OFF);
  assign next_rts_n = rts_on ? 1'b0 : rts_off ? 1'b1 : chan_a_request_to_send_n;

  // Pin 0 and pin 1 handover is owned by the channel mode registers
  assign pin0_rts = chan_a_mode_one_i[`MODE1_ALT_BIT];
  assign pin0_alt = pin0_rts || chan_a_mode_two_i[`MODE2_ALT_BIT];
  assign pin0_value = pin0_rts ? chan_a_request_to_send_n : chan_a_alt_i;
  assign pin1_alt = chan_b_mode_one_i[`MODE1_ALT_BIT] || chan_b_mode_two_i[`MODE2_ALT_BIT];

  // Alternate pins are masked out so the latch keeps its old level
  assign assert_mask = wr_assert ? (wdata_i & ~alt_mask) : `RST_BYTE;
  assign negate_mask = wr_negate ? (wdata_i & ~alt_mask) : `RST_BYTE;
  assign next_gp_latch = (gp_latch & ~assert_mask) | negate_mask;

  // Terminal count wins over a stop in the same cycle so it is not lost
  assign next_ct_low = (ct_terminal_i && !timer_mode_i) ? 1'b1 :
                       rd_stop ? 1'b0 : ct_low;
  assign ct_pin_value = timer_mode_i ? ct_out_i : ~ct_low;
  // A running square wave must not be stopped by the stop register
  assign next_halt = rd_stop && !timer_mode_i;

  // Start and stop reads return zero; software ignores them anyway
  assign next_rdata = rd_level ? output_pin_o :
                      rd_latch ? gp_latch : `RST_BYTE;

  output_source_mux u_mux (
    .func_sel_i(func_sel),
    .gp_latch_i(gp_latch),
    .interrupt_status_i(interrupt_status_i),
    .pin0_alt_i(pin0_alt),
    .pin0_value_i(pin0_value),
    .pin1_alt_i(pin1_alt),
    .pin1_value_i(chan_b_alt_i),
    .chan_a_tx_clock_x16_i(chan_a_tx_clock_x16_i),
    .chan_a_tx_clock_x1_i(chan_a_tx_clock_x1_i),
    .chan_a_rx_clock_x1_i(chan_a_rx_clock_x1_i),
    .chan_b_tx_clock_x1_i(chan_b_tx_clock_x1_i),
    .chan_b_rx_clock_x1_i(chan_b_rx_clock_x1_i),
    .ct_pin_value_i(ct_pin_value),
    .next_pins_o(next_pins),
    .alt_mask_o(alt_mask)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      func_sel <= `RST_FUNC_SEL;
      gp_latch <= `RST_GP_LATCH;
      chan_a_request_to_send_n <= 1'b1;
      ct_low <= 1'b0;
    end else begin
      if (wr_func) begin
        func_sel <= wdata_i;
      end
      gp_latch <= next_gp_latch;
      chan_a_request_to_send_n <= next_rts_n;
      ct_low <= next_ct_low;
    end
  end

  // Pins are registered, so clock sources appear one cycle late
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      output_pin_o <= `RST_GP_LATCH;
      rdata_o <= `RST_BYTE;
      timer_start_o <= 1'b0;
      timer_halt_o <= 1'b0;
      timer_ready_clear_o <= 1'b0;
    end else begin
      output_pin_o <= next_pins;
      rdata_o <= next_rdata;
      timer_start_o <= rd_start;
      timer_halt_o <= next_halt;
      timer_ready_clear_o <= rd_stop;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_reset_all_high: assert property (disable iff (1'b0) rst_i |=>
    (gp_latch == `RST_GP_LATCH) && (func_sel == `RST_FUNC_SEL) && (output_pin_o == `RST_GP_LATCH))
    else $error("reset did not return pins to general purpose high");

  a_pin2_tx16: assert property ($past(func_sel[1:0]) == 2'h1 |->
    output_pin_o[2] == $past(chan_a_tx_clock_x16_i))
    else $error("pin 2 does not follow channel A x16 transmit clock");

  a_pin3_rx_b: assert property ($past(func_sel[3:2]) == 2'h3 |->
    output_pin_o[3] == $past(chan_b_rx_clock_x1_i))
    else $error("pin 3 does not follow channel B receive clock");

  a_counter_terminal_low: assert property (!timer_mode_i && ct_terminal_i &&
    func_sel[3:2] == 2'h1 ##1 func_sel[3:2] == 2'h1 && !timer_mode_i |=> !output_pin_o[3])
    else $error("pin 3 not low after terminal count");

  a_counter_low_holds: assert property (ct_low && !rd_stop |=> ct_low)
    else $error("counter output left low state without a stop");

  a_pin4_rx_a: assert property ($past(func_sel[4]) |->
    output_pin_o[4] == !$past(interrupt_status_i[1]))
    else $error("pin 4 is not inverted channel A receive ready");

  a_pin5_rx_b: assert property ($past(func_sel[5]) |->
    output_pin_o[5] == !$past(interrupt_status_i[5]))
    else $error("pin 5 is not inverted channel B receive ready");

  a_pin6_tx_a: assert property ($past(func_sel[6]) |->
    output_pin_o[6] == !$past(interrupt_status_i[0]))
    else $error("pin 6 is not inverted channel A transmit ready");

  a_pin7_tx_b: assert property ($past(func_sel[7]) |->
    output_pin_o[7] == !$past(interrupt_status_i[4]))
    else $error("pin 7 is not inverted channel B transmit ready");

  a_pin1_mode_alt: assert property ($past(pin1_alt) |->
    output_pin_o[1] == $past(chan_b_alt_i))
    else $error("pin 1 not handed to channel B");

  a_start_read_pulse: assert property (rd_start |=> timer_start_o && rdata_o == 8'h00)
    else $error("start read did not pulse the timer start");

  a_stop_counter_halt: assert property (rd_stop && !timer_mode_i |=>
    timer_halt_o && timer_ready_clear_o && rdata_o == 8'h00)
    else $error("stop read did not halt the counter");

  a_assert_low: assert property (wr_assert |=>
    (gp_latch & $past(assert_mask)) == 8'h00)
    else $error("assert write left a pin high");

  a_negate_high: assert property (wr_negate |=>
    (gp_latch & $past(negate_mask)) == $past(negate_mask))
    else $error("negate write left a pin low");

  a_low_until_negate: assert property (1'b1 |=>
    (gp_latch & ~$past(gp_latch) & ~$past(negate_mask)) == 8'h00)
    else $error("latch bit rose without a negate write");

  a_alt_untouched: assert property (wr_assert || wr_negate |=>
    ((gp_latch ^ $past(gp_latch)) & $past(alt_mask)) == 8'h00)
    else $error("latch write touched an alternate function pin");

  a_rts_command: assert property (rts_on ##1 !wr_cmd && pin0_rts |=> !output_pin_o[0])
    else $error("request-to-send not asserted on pin 0");

  a_timer_keeps_running: assert property (rd_stop && timer_mode_i |=>
    !timer_halt_o && timer_ready_clear_o)
    else $error("stop in timer mode halted the timer");

  a_pin2_tx1: assert property ($past(func_sel[1:0]) == 2'h2 |->
    output_pin_o[2] == $past(chan_a_tx_clock_x1_i))
    else $error("pin 2 does not follow channel A x1 transmit clock");

  a_pin2_rx_a: assert property ($past(func_sel[1:0]) == 2'h3 |->
    output_pin_o[2] == $past(chan_a_rx_clock_x1_i))
    else $error("pin 2 does not follow channel A receive clock");

  a_pin2_latch: assert property ($past(func_sel[1:0]) == 2'h0 |->
    output_pin_o[2] == $past(gp_latch[2]))
    else $error("pin 2 does not follow its latch bit");

  a_pin3_timer: assert property ($past(func_sel[3:2]) == 2'h1 && $past(timer_mode_i) |->
    output_pin_o[3] == $past(ct_out_i))
    else $error("pin 3 does not follow the timer square wave");

  a_pin3_tx_b: assert property ($past(func_sel[3:2]) == 2'h2 |->
    output_pin_o[3] == $past(chan_b_tx_clock_x1_i))
    else $error("pin 3 does not follow channel B transmit clock");

  a_pin3_latch: assert property ($past(func_sel[3:2]) == 2'h0 |->
    output_pin_o[3] == $past(gp_latch[3]))
    else $error("pin 3 does not follow its latch bit");

  a_stop_releases: assert property (rd_stop && !(ct_terminal_i && !timer_mode_i) |=>
    !ct_low)
    else $error("stop did not release the counter output");

  a_ready_pins_latch: assert property (1'b1 |->
    ((output_pin_o ^ $past(gp_latch)) & ~$past(func_sel) & 8'hf0) == 8'h00)
    else $error("general purpose upper pin does not follow its latch bit");

  a_rts_negate: assert property (rts_off |=> chan_a_request_to_send_n)
    else $error("request-to-send not negated by command");

  a_pin0_mode_alt: assert property ($past(pin0_alt) && !$past(pin0_rts) |->
    output_pin_o[0] == $past(chan_a_alt_i))
    else $error("pin 0 not handed to channel A");

  a_start_only_read: assert property (timer_start_o |-> $past(rd_start))
    else $error("timer start pulse without a start read");

  a_halt_only_stop: assert property (timer_halt_o |->
    $past(rd_stop) && !$past(timer_mode_i))
    else $error("timer halt pulse without a counter mode stop read");

  a_latch_idle: assert property (!wr_assert && !wr_negate |=>
    gp_latch == $past(gp_latch))
    else $error("latch changed without a latch write");

  a_reset_rts: assert property (disable iff (1'b0) rst_i |=>
    chan_a_request_to_send_n && !ct_low && !timer_start_o && !timer_halt_o)
    else $error("reset did not clear request-to-send and timer state");

  c_assert_then_negate: cover property (wr_assert ##1 wr_negate);
  c_counter_cycle: cover property (!timer_mode_i && ct_terminal_i ##[1:20] rd_stop);
  c_timer_on_pin3: cover property (rd_start ##[1:10] wr_func && wdata_i[3:2] == 2'h1);
  c_rts_toggle: cover property (rts_on ##[1:10] rts_off);

endmodule : multipurpose_output_port
`default_nettype wire

// file: pkg/mpo_params.svh
`ifndef MPO_PARAMS_SVH
`define MPO_PARAMS_SVH

// Register offsets on the plain register port
`define OFS_FUNC_SEL 4'h0
`define OFS_ASSERT 4'h1
`define OFS_NEGATE 4'h2
`define OFS_START 4'h3
`define OFS_STOP 4'h4
`define OFS_CHA_CMD 4'h5
`define OFS_PIN_LEVEL 4'h6
`define OFS_GP_LATCH 4'h7

// Function select field positions
`define FLD_PIN2_HI 1
`define FLD_PIN2_LO 0
`define FLD_PIN3_HI 3
`define FLD_PIN3_LO 2

// Interrupt status bit positions
`define ISR_TX_A 0
`define ISR_RX_A 1
`define ISR_TX_B 4
`define ISR_RX_B 5

// Mode register bits that hand pins 0 and 1 to the channels
`define MODE1_ALT_BIT 7
`define MODE2_ALT_BIT 5

// Channel A command upper nibble
`define CMD_NIB_HI 7
`define CMD_NIB_LO 4
`define CMD_RTS_ON 4'h8
`define CMD_RTS_OFF 4'h9

// Reset values
`define RST_FUNC_SEL 8'h00
`define RST_GP_LATCH 8'hff
`define RST_BYTE 8'h00

`endif

// file: pkg/mpo_pkg.sv
package mpo_pkg;

  typedef logic [3:0] addr_type;
  typedef logic [7:0] byte_type;

  typedef enum logic [1:0] {
    P2_GP = 2'h0,
    P2_TXA16 = 2'h1,
    P2_TXA1 = 2'h2,
    P2_RXA1 = 2'h3
  } pin2_sel_type;

  typedef enum logic [1:0] {
    P3_GP = 2'h0,
    P3_CT = 2'h1,
    P3_TXB1 = 2'h2,
    P3_RXB1 = 2'h3
  } pin3_sel_type;

endpackage : mpo_pkg

// file: core/output_source_mux.sv
`timescale 1ns/1ps
`default_nettype none
`include "mpo_params.svh"

module output_source_mux
  import mpo_pkg::*;
(
  input wire logic [7:0] func_sel_i,
  input wire logic [7:0] gp_latch_i,
  input wire logic [7:0] interrupt_status_i,
  input wire logic pin0_alt_i,
  input wire logic pin0_value_i,
  input wire logic pin1_alt_i,
  input wire logic pin1_value_i,
  input wire logic chan_a_tx_clock_x16_i,
  input wire logic chan_a_tx_clock_x1_i,
  input wire logic chan_a_rx_clock_x1_i,
  input wire logic chan_b_tx_clock_x1_i,
  input wire logic chan_b_rx_clock_x1_i,
  input wire logic ct_pin_value_i,
  output logic [7:0] next_pins_o,
  output logic [7:0] alt_mask_o
);

  pin2_sel_type sel2;
  pin3_sel_type sel3;
  logic alt2;
  logic alt3;

  assign sel2 = pin2_sel_type'(func_sel_i[`FLD_PIN2_HI:`FLD_PIN2_LO]);
  assign sel3 = pin3_sel_type'(func_sel_i[`FLD_PIN3_HI:`FLD_PIN3_LO]);
  assign alt2 = (sel2 != P2_GP);
  assign alt3 = (sel3 != P3_GP);

  assign alt_mask_o[0] = pin0_alt_i;
  assign alt_mask_o[1] = pin1_alt_i;
  assign alt_mask_o[2] = alt2;
  assign alt_mask_o[3] = alt3;
  assign next_pins_o[0] = pin0_alt_i ? pin0_value_i : gp_latch_i[0];
  assign next_pins_o[1] = pin1_alt_i ? pin1_value_i : gp_latch_i[1];

  assign next_pins_o[2] = (sel2 == P2_TXA16) ? chan_a_tx_clock_x16_i :
                          (sel2 == P2_TXA1) ? chan_a_tx_clock_x1_i :
                          (sel2 == P2_RXA1) ? chan_a_rx_clock_x1_i : gp_latch_i[2];
  assign next_pins_o[3] = (sel3 == P3_CT) ? ct_pin_value_i :
                          (sel3 == P3_TXB1) ? chan_b_tx_clock_x1_i :
                          (sel3 == P3_RXB1) ? chan_b_rx_clock_x1_i : gp_latch_i[3];

  // Ready flags leave the pins active low, inverted from the status bits
  genvar i;
  generate
    for (i = 4; i < 8; i++) begin : g_ready_pin
      localparam int ISR_IDX = (i == 4) ? `ISR_RX_A : (i == 5) ? `ISR_RX_B :
                               (i == 6) ? `ISR_TX_A : `ISR_TX_B;
      assign alt_mask_o[i] = func_sel_i[i];
      assign next_pins_o[i] = func_sel_i[i] ? ~interrupt_status_i[ISR_IDX] : gp_latch_i[i];
    end
  endgenerate

endmodule : output_source_mux
`default_nettype wire

// file: bench/pin_load_model.sv
`timescale 1ns/1ps
`default_nettype none

module pin_load_model (
  input wire logic clk_i,
  input wire logic [7:0] pins_i,
  output logic [7:0] falls_o
);
  // Falling edge counter on pin 3; a glitch on the pin shows up as an extra count
  logic last = 1'b1;
  logic [7:0] n_falls = 8'h00;
  assign falls_o = n_falls;
  always @(posedge clk_i) begin
    last <= pins_i[3];
    if (last && !pins_i[3]) begin
      n_falls <= n_falls + 8'h01;
    end
  end
endmodule : pin_load_model

`default_nettype wire

// file: bench/test_multipurpose_output_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "mpo_params.svh"

module test_multipurpose_output_port
  import mpo_pkg::*;
  ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  addr_type addr = 4'h0;
  byte_type wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  byte_type rdata, pins, falls, got, f0;
  logic t_start, t_halt, t_clr, s_start, s_halt, s_clr;
  byte_type mode_a1 = 8'h00;
  byte_type mode_b2 = 8'h00;
  byte_type mode_a2 = 8'h00;
  logic alt_a = 1'b0;
  byte_type status = 8'h00;
  logic alt_b = 1'b0;
  logic tmode = 1'b0;
  logic ct_out = 1'b0;
  logic term = 1'b0;
  logic [4:0] clks = 5'h00;
  int n_fail = 0;
  int total_checks = 0;

  always #4 clk = ~clk;

  multipurpose_output_port dut (
    .clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .chan_a_mode_one_i(mode_a1), .chan_a_mode_two_i(mode_a2),
    .chan_b_mode_one_i(8'h00), .chan_b_mode_two_i(mode_b2), .chan_a_alt_i(alt_a),
    .chan_b_alt_i(alt_b), .chan_a_tx_clock_x16_i(clks[0]), .chan_a_tx_clock_x1_i(clks[1]),
    .chan_a_rx_clock_x1_i(clks[2]), .chan_b_tx_clock_x1_i(clks[3]),
    .chan_b_rx_clock_x1_i(clks[4]), .timer_mode_i(tmode), .ct_out_i(ct_out),
    .ct_terminal_i(term), .interrupt_status_i(status), .output_pin_o(pins),
    .timer_start_o(t_start), .timer_halt_o(t_halt), .timer_ready_clear_o(t_clr)
  );

  pin_load_model load (.clk_i(clk), .pins_i(pins), .falls_o(falls));

  task automatic chk(input string what, input byte_type exp, input byte_type seen);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input addr_type a, input byte_type d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input addr_type a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    got = rdata;
    s_start = t_start;
    s_halt = t_halt;
    s_clr = t_clr;
  endtask : rd_reg

  // Pins are registered, so a change is seen one edge after it is taken
  task automatic settle;
    @(posedge clk);
    #1;
  endtask : settle

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  // The sequence needs some 110 cycles; 5000 leaves ample margin
  initial begin
    #40000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("pins reset", 8'hff, pins);
    rd_reg(`OFS_FUNC_SEL);
    chk("select read", 8'h00, got);
    wr_reg(`OFS_ASSERT, 8'h0f);
    settle();
    chk("assert", 8'hf0, pins);
    wr_reg(`OFS_ASSERT, 8'h00);
    wr_reg(`OFS_NEGATE, 8'h00);
    wr_reg(4'hf, 8'hff);
    settle();
    chk("hold low", 8'hf0, pins);
    wr_reg(`OFS_NEGATE, 8'h01);
    settle();
    chk("negate", 8'hf1, pins);
    rd_reg(4'hf);
    chk("unmapped", 8'h00, got);
    wr_reg(`OFS_FUNC_SEL, 8'hf0);
    @(posedge clk);
    status <= 8'h12;
    settle();
    chk("status 12", 8'h61, pins);
    @(posedge clk);
    status <= 8'h21;
    wr_reg(`OFS_ASSERT, 8'hf0);
    settle();
    chk("status 21", 8'h91, pins);
    rd_reg(`OFS_GP_LATCH);
    chk("latch", 8'hf1, got);
    wr_reg(`OFS_FUNC_SEL, 8'h00);
    settle();
    chk("back to latch", 8'hf1, pins);
    for (int c = 1; c < 6; c++) begin
      wr_reg(`OFS_FUNC_SEL, (c < 4) ? 8'(c) : (8'(c - 2) << 2));
      for (int v = 0; v < 2; v++) begin
        @(posedge clk);
        clks <= v[0] ? (5'h01 << (c - 1)) : ~(5'h01 << (c - 1));
        settle();
        chk("clock pin", {7'h00, v[0]}, {7'h00, pins[(c < 4) ? 2 : 3]});
      end
    end
    @(posedge clk);
    clks <= 5'h00;
    // Host arms the timer before handing pin 3 to it
    rd_reg(`OFS_START);
    chk("start", 8'h01, {7'h00, s_start});
    wr_reg(`OFS_FUNC_SEL, 8'h04);
    settle();
    chk("count high", 8'h01, {7'h00, pins[3]});
    f0 = falls;
    @(posedge clk);
    term <= 1'b1;
    @(posedge clk);
    term <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk("count low", 8'h00, {7'h00, pins[3]});
    chk("one fall", f0 + 8'h01, falls);
    rd_reg(`OFS_STOP);
    chk("halt", 8'h01, {7'h00, s_halt});
    chk("clear", 8'h01, {7'h00, s_clr});
    settle();
    chk("count restored", 8'h01, {7'h00, pins[3]});
    @(posedge clk);
    tmode <= 1'b1;
    ct_out <= 1'b1;
    settle();
    rd_reg(`OFS_STOP);
    chk("timer no halt", 8'h00, {7'h00, s_halt});
    chk("timer clear", 8'h01, {7'h00, s_clr});
    @(posedge clk);
    ct_out <= 1'b0;
    settle();
    chk("square wave", 8'h00, {7'h00, pins[3]});
    @(posedge clk);
    mode_a1 <= 8'h80;
    wr_reg(`OFS_CHA_CMD, 8'h80);
    wr_reg(`OFS_NEGATE, 8'h01);
    settle();
    chk("rts on", 8'h00, {7'h00, pins[0]});
    wr_reg(`OFS_CHA_CMD, 8'h90);
    wr_reg(`OFS_ASSERT, 8'h01);
    settle();
    chk("rts off", 8'h01, {7'h00, pins[0]});
    @(posedge clk);
    mode_b2 <= 8'h20;
    alt_b <= 1'b1;
    settle();
    chk("pin1 alt", 8'h01, {7'h00, pins[1]});
    rd_reg(`OFS_GP_LATCH);
    chk("latch kept", 8'hf1, got);
    @(posedge clk);
    mode_a1 <= 8'h00;
    mode_a2 <= 8'h20;
    settle();
    chk("pin0 alt", 8'h00, {7'h00, pins[0]});
    @(posedge clk);
    alt_a <= 1'b1;
    settle();
    chk("pin0 alt high", 8'h01, {7'h00, pins[0]});
    rd_reg(`OFS_PIN_LEVEL);
    chk("pin level", 8'hf3, got);
    report_and_stop();
  end
endmodule : test_multipurpose_output_port

`default_nettype wire
